/* overlay_serial_port.sv */
// Main serial port, debug port and flow control of the overlay module
module overlay_serial_port
    import overlay_serial_pkg::*;
#(
    parameter int STARTUP_WAIT = STARTUP_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Configuration straps
    input wire logic [3:0] rate_config_straps,
    // Software setup command
    input wire logic cfg_wr,
    input wire logic [1:0] cfg_rate,
    input wire logic cfg_hw_flow,
    input wire logic echo_en,
    // Main serial port pins
    input wire logic rxd,
    output logic txd,
    output logic rts,
    input wire logic cts,
    // Debug port pin
    output logic dbg_txd,
    // SPI received bytes for debug report
    input wire logic spi_rx_valid,
    input wire logic [7:0] spi_rx_data,
    // Received characters to the command parser
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic rx_ready,
    // Characters from the command parser to send
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    // Status
    output logic online,
    output logic hw_flow_active,
    output logic [1:0] rate_sel,
    output logic rx_dropped
);
    ////////////////////////////////////////////////////////////////////////
    // Configuration
    logic init_q, init_d;
    logic [1:0] rate_q, rate_d;
    logic hw_q, hw_d;
    logic swcfg_q, swcfg_d;
    logic [15:0] main_div;

    always_comb begin
        init_d = 1'b1;
        rate_d = rate_q;
        hw_d = hw_q;
        swcfg_d = swcfg_q;
        if (!init_q) begin
            rate_d = rate_config_straps[STRAP_RATE_LSB +: 2];
            hw_d = rate_config_straps[STRAP_HW_FLOW_BIT];
            swcfg_d = rate_config_straps[STRAP_SW_CFG_BIT];
        end else if (cfg_wr && swcfg_q) begin
            rate_d = cfg_rate;
            hw_d = cfg_hw_flow;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            init_q <= 1'b0;
            rate_q <= RATE_RST;
            hw_q <= HW_FLOW_RST;
            swcfg_q <= SW_CFG_RST;
        end else begin
            init_q <= init_d;
            rate_q <= rate_d;
            hw_q <= hw_d;
            swcfg_q <= swcfg_d;
        end
    end

    always_comb begin
        if (rate_q == 2'h0) begin
            main_div = DIV_RATE0;
        end else if (rate_q == 2'h1) begin
            main_div = DIV_RATE1;
        end else if (rate_q == 2'h2) begin
            main_div = DIV_RATE2;
        end else begin
            main_div = DIV_RATE3;
        end
    end

    assign hw_flow_active = hw_q;
    assign rate_sel = rate_q;

    ////////////////////////////////////////////////////////////////////////
    // Receiver: 8N1 frame into the holding register
    rx_state_t st_q, st_d;
    logic [15:0] rcnt_q, rcnt_d;
    logic [2:0] rbit_q, rbit_d;
    logic [7:0] rsh_q, rsh_d;
    logic drop_q, drop_d;
    logic rdone;
    logic [7:0] hold_q, hold_d;
    logic hold_v_q, hold_v_d;
    logic dropped_q, dropped_d;
    logic [1:0] fill;
    logic rts_q, rts_d;
    byte_stream_if rx_in ();
    byte_stream_if rx_out ();

    always_comb begin
        st_d = st_q;
        rcnt_d = rcnt_q;
        rbit_d = rbit_q;
        rsh_d = rsh_q;
        drop_d = drop_q;
        rdone = 1'b0;
        case (st_q)
            RX_IDLE: begin
                if (!rxd) begin
                    st_d = RX_START;
                    rcnt_d = main_div >> 1;
                    drop_d = rts_q;
                end
            end
            RX_START: begin
                if (rcnt_q == 16'h0000) begin
                    st_d = rxd ? RX_IDLE : RX_DATA;
                    rcnt_d = main_div - 16'h0001;
                    rbit_d = 3'h0;
                end else begin
                    rcnt_d = rcnt_q - 16'h0001;
                end
            end
            RX_DATA: begin
                if (rcnt_q == 16'h0000) begin
                    rsh_d = {rxd, rsh_q[7:1]};
                    rcnt_d = main_div - 16'h0001;
                    rbit_d = rbit_q + 3'h1;
                    if (rbit_q == LAST_DATA_BIT) begin
                        st_d = RX_STOP;
                    end
                end else begin
                    rcnt_d = rcnt_q - 16'h0001;
                end
            end
            RX_STOP: begin
                if (rcnt_q == 16'h0000) begin
                    st_d = RX_IDLE;
                    rdone = rxd && !drop_q;
                end else begin
                    rcnt_d = rcnt_q - 16'h0001;
                end
            end
            default: st_d = RX_IDLE;
        endcase
    end

    always_comb begin
        hold_d = hold_q;
        hold_v_d = hold_v_q;
        dropped_d = 1'b0;
        if (hold_v_q && rx_in.ready) begin
            hold_v_d = 1'b0;
        end
        if (rdone && !hold_v_d) begin
            hold_d = rsh_q;
            hold_v_d = 1'b1;
        end else if (rdone) begin
            dropped_d = 1'b1;
        end
        if (st_q == RX_STOP && rcnt_q == 16'h0000 && drop_q) begin
            dropped_d = 1'b1;
        end
    end

    assign rx_in.valid = hold_v_q;
    assign rx_in.data = hold_q;
    assign rx_out.ready = rx_ready;
    assign rx_valid = rx_out.valid;
    assign rx_data = rx_out.data;
    assign rx_dropped = dropped_q;

    two_entry_buffer u_rx_buf (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .in_s(rx_in),
        .out_s(rx_out),
        .fill(fill)
    );

    assign rts_d = hw_q && (fill == FILL_FULL);
    assign rts = rts_q;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st_q <= RX_IDLE;
            rcnt_q <= 16'h0000;
            rbit_q <= 3'h0;
            rsh_q <= 8'h00;
            drop_q <= 1'b0;
            hold_q <= 8'h00;
            hold_v_q <= 1'b0;
            dropped_q <= 1'b0;
            rts_q <= 1'b0;
        end else begin
            st_q <= st_d;
            rcnt_q <= rcnt_d;
            rbit_q <= rbit_d;
            rsh_q <= rsh_d;
            drop_q <= drop_d;
            hold_q <= hold_d;
            hold_v_q <= hold_v_d;
            dropped_q <= dropped_d;
            rts_q <= rts_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmitters: index 0 main port, index 1 debug port
    logic [1:0] ld, busy, line;
    logic [7:0] tbyte [2];
    logic [15:0] tdiv [2];

    assign tdiv[0] = main_div;
    assign tdiv[1] = DBG_DIV;
    assign txd = line[0];
    assign dbg_txd = line[1];

    for (genvar i = 0; i < 2; i++) begin : g_tx
        logic [8:0] fr_q, fr_d;
        logic [15:0] cnt_q, cnt_d;
        logic [3:0] left_q, left_d;
        logic line_q, line_d;

        assign busy[i] = (left_q != 4'h0);
        assign line[i] = line_q;

        always_comb begin
            fr_d = fr_q;
            cnt_d = cnt_q;
            left_d = left_q;
            line_d = line_q;
            if (ld[i]) begin
                fr_d = {1'b1, tbyte[i]};
                cnt_d = tdiv[i] - 16'h0001;
                left_d = FRAME_PERIODS;
                line_d = 1'b0;
            end else if (left_q != 4'h0) begin
                if (cnt_q == 16'h0000) begin
                    cnt_d = tdiv[i] - 16'h0001;
                    left_d = left_q - 4'h1;
                    line_d = (left_q == 4'h1) ? 1'b1 : fr_q[0];
                    fr_d = {1'b1, fr_q[8:1]};
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
        end

        always_ff @(posedge ref_clk) begin
            if (!rstn) begin
                fr_q <= 9'h1ff;
                cnt_q <= 16'h0000;
                left_q <= 4'h0;
                line_q <= 1'b1;
            end else begin
                fr_q <= fr_d;
                cnt_q <= cnt_d;
                left_q <= left_d;
                line_q <= line_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main transmit sources: announcement, flow chars, echo, parser
    logic [24:0] up_q, up_d;
    logic online_q, online_d;
    logic xon_pend_q, xon_pend_d;
    logic fc_pend_q, fc_pend_d;
    logic [7:0] fc_char_q, fc_char_d;
    logic xoff_sent_q, xoff_sent_d;
    logic echo_pend_q, echo_pend_d;
    logic [7:0] echo_q, echo_d;
    logic tx_free;

    // Only CTS stalls, in hardware flow mode; host XON/XOFF bytes are plain data here
    assign tx_free = online_q && !busy[0] && !(hw_q && cts);
    assign tx_ready = tx_free && !xon_pend_q && !fc_pend_q && !echo_pend_q;
    assign online = online_q;

    always_comb begin
        up_d = up_q;
        online_d = online_q;
        xon_pend_d = xon_pend_q;
        fc_pend_d = fc_pend_q;
        fc_char_d = fc_char_q;
        xoff_sent_d = xoff_sent_q;
        echo_pend_d = echo_pend_q;
        echo_d = echo_q;
        ld[0] = 1'b0;
        tbyte[0] = tx_data;
        if (!online_q) begin
            if (up_q == 25'(STARTUP_WAIT - 1)) begin
                online_d = 1'b1;
                xon_pend_d = 1'b1;
            end else begin
                up_d = up_q + 25'h0000001;
            end
        end
        if (tx_free) begin
            if (xon_pend_q) begin
                ld[0] = 1'b1;
                tbyte[0] = XON_CHAR;
                xon_pend_d = 1'b0;
            end else if (fc_pend_q) begin
                ld[0] = 1'b1;
                tbyte[0] = fc_char_q;
                fc_pend_d = 1'b0;
            end else if (echo_pend_q) begin
                ld[0] = 1'b1;
                tbyte[0] = echo_q;
                echo_pend_d = 1'b0;
            end else if (tx_valid) begin
                ld[0] = 1'b1;
            end
        end
        if (online_q && !hw_q) begin
            if (!xoff_sent_q && fill == FILL_HIGH) begin
                xoff_sent_d = 1'b1;
                fc_pend_d = 1'b1;
                fc_char_d = XOFF_CHAR;
            end else if (xoff_sent_q && fill == FILL_LOW) begin
                xoff_sent_d = 1'b0;
                fc_pend_d = 1'b1;
                fc_char_d = XON_CHAR;
            end
        end
        if (rdone && !hold_v_q && echo_en) begin
            echo_pend_d = 1'b1;
            echo_d = rsh_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            up_q <= 25'h0000000;
            online_q <= 1'b0;
            xon_pend_q <= 1'b0;
            fc_pend_q <= 1'b0;
            fc_char_q <= XON_CHAR;
            xoff_sent_q <= 1'b0;
            echo_pend_q <= 1'b0;
            echo_q <= 8'h00;
        end else begin
            up_q <= up_d;
            online_q <= online_d;
            xon_pend_q <= xon_pend_d;
            fc_pend_q <= fc_pend_d;
            fc_char_q <= fc_char_d;
            xoff_sent_q <= xoff_sent_d;
            echo_pend_q <= echo_pend_d;
            echo_q <= echo_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Debug report of main and SPI received characters
    logic dm_pend_q, dm_pend_d, ds_pend_q, ds_pend_d;
    logic [7:0] dm_q, dm_d, ds_q, ds_d;

    always_comb begin
        dm_pend_d = dm_pend_q;
        ds_pend_d = ds_pend_q;
        dm_d = dm_q;
        ds_d = ds_q;
        ld[1] = 1'b0;
        tbyte[1] = dm_q;
        if (!busy[1]) begin
            if (dm_pend_q) begin
                ld[1] = 1'b1;
                dm_pend_d = 1'b0;
            end else if (ds_pend_q) begin
                ld[1] = 1'b1;
                tbyte[1] = ds_q;
                ds_pend_d = 1'b0;
            end
        end
        if (rdone) begin
            dm_pend_d = 1'b1;
            dm_d = rsh_q;
        end
        if (spi_rx_valid) begin
            ds_pend_d = 1'b1;
            ds_d = spi_rx_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            dm_pend_q <= 1'b0;
            ds_pend_q <= 1'b0;
            dm_q <= 8'h00;
            ds_q <= 8'h00;
        end else begin
            dm_pend_q <= dm_pend_d;
            ds_pend_q <= ds_pend_d;
            dm_q <= dm_d;
            ds_q <= ds_d;
        end
    end
endmodule

/* overlay_serial_pkg.sv */
// Constants and types for the overlay serial port with flow control
package overlay_serial_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and bit timing
    localparam int CLK_HZ = 50_000_000;
    localparam int BAUD_RATE0 = 9600;
    localparam int BAUD_RATE1 = 19200;
    localparam int BAUD_RATE2 = 38400;
    localparam int BAUD_RATE3 = 115200;
    localparam int DBG_BAUD = 115200;
    localparam logic [15:0] DIV_RATE0 = 16'(CLK_HZ / BAUD_RATE0);
    localparam logic [15:0] DIV_RATE1 = 16'(CLK_HZ / BAUD_RATE1);
    localparam logic [15:0] DIV_RATE2 = 16'(CLK_HZ / BAUD_RATE2);
    localparam logic [15:0] DIV_RATE3 = 16'(CLK_HZ / BAUD_RATE3);
    localparam logic [15:0] DBG_DIV = 16'(CLK_HZ / DBG_BAUD);

    ////////////////////////////////////////////////////////////////////////
    // Frame layout: 8 data bits, no parity, one stop bit
    localparam logic [2:0] LAST_DATA_BIT = 3'd7;
    localparam logic [3:0] FRAME_PERIODS = 4'd10;

    ////////////////////////////////////////////////////////////////////////
    // Start-up delay before the online announcement
    localparam int STARTUP_TIME_MS = 500;
    localparam int STARTUP_CYCLES = STARTUP_TIME_MS * (CLK_HZ / 1000);

    ////////////////////////////////////////////////////////////////////////
    // Flow control characters and fill thresholds
    localparam logic [7:0] XON_CHAR = 8'h11;
    localparam logic [7:0] XOFF_CHAR = 8'h13;
    localparam logic [1:0] FILL_FULL = 2'h2;
    localparam logic [1:0] FILL_HIGH = 2'h2;
    localparam logic [1:0] FILL_LOW = 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // Strap field positions and reset values
    localparam int STRAP_RATE_LSB = 0;
    localparam int STRAP_HW_FLOW_BIT = 2;
    localparam int STRAP_SW_CFG_BIT = 3;
    localparam logic [1:0] RATE_RST = 2'h0;
    localparam logic HW_FLOW_RST = 1'b0;
    localparam logic SW_CFG_RST = 1'b0;

    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

endpackage

/* byte_stream_if.sv */
// Byte stream carrier with valid and ready between the block's modules
interface byte_stream_if;
    logic valid;
    logic ready;
    logic [7:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* two_entry_buffer.sv */
// Two-entry receive buffer with fill count
module two_entry_buffer
    import overlay_serial_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Streams
    byte_stream_if.snk in_s,
    byte_stream_if.src out_s,
    // Fill level
    output logic [1:0] fill
);
    logic [7:0] mem_q [2];
    logic [7:0] mem_d [2];
    logic wr_q, wr_d, rd_q, rd_d;
    logic [1:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_s.ready = (cnt_q != FILL_FULL);
    assign out_s.valid = (cnt_q != 2'h0);
    assign out_s.data = mem_q[rd_q];
    assign fill = cnt_q;
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    always_comb begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wr_q] = in_s.data;
            wr_d = ~wr_q;
        end
        if (pop) begin
            rd_d = ~rd_q;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 2'h1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 2'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            mem_q[0] <= 8'h00;
            mem_q[1] <= 8'h00;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            mem_q <= mem_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end
endmodule

/* overlay_serial_host.sv */
// Host UART model facing the main serial port or the debug port
module overlay_serial_host (
    // Line side
    input wire logic ref_clk,
    input wire logic line_in,
    input wire logic rts,
    output logic line_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int div = 434;
    logic [7:0] got[$];
    logic [7:0] sh;
    initial line_out = 1'b1;
    ////////////////////////////////////////////////////////////////////////
    // Sender, 8N1 LSB first; obey low starts a frame despite rts
    task automatic send_byte(input logic [7:0] b, input bit obey);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        @(negedge ref_clk);
        while (obey && rts === 1'b1) @(negedge ref_clk);
        for (int i = 0; i < 10; i++) begin
            line_out <= fr[i];
            repeat (div) @(negedge ref_clk);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Receiver, frames with a bad start or stop are thrown away
    initial forever begin
        @(negedge line_in);
        repeat (div / 2) @(posedge ref_clk);
        if (line_in === 1'b0) begin
            for (int i = 0; i < 8; i++) begin
                repeat (div) @(posedge ref_clk);
                sh[i] = line_in;
            end
            repeat (div) @(posedge ref_clk);
            if (line_in === 1'b1) got.push_back(sh);
        end
    end
endmodule

/* overlay_serial_port_assertions.sv */
// Pin-level checks of the overlay serial port
module overlay_serial_port_checker
    import overlay_serial_pkg::*;
#(
    parameter int STARTUP_WAIT = STARTUP_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Inputs
    input wire logic cfg_wr,
    input wire logic cts,
    input wire logic rx_ready,
    input wire logic tx_valid,
    // Outputs
    input wire logic txd,
    input wire logic rts,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic tx_ready,
    input wire logic online,
    input wire logic hw_flow_active,
    input wire logic [1:0] rate_sel,
    input wire logic rx_dropped
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    int unsigned up_q;
    int unsigned up_d;
    always_comb begin
        up_d = up_q;
        if (up_q != 32'hffffffff) up_d = up_q + 32'h1;
    end
    always_ff @(posedge ref_clk) begin
        if (!rstn) up_q <= 32'h0;
        else up_q <= up_d;
    end
    ////////////////////////////////////////////////////////////////////////
    chk_rts_sw_off: assert property (!hw_flow_active |-> !rts)
        else $error("rts raised in software flow mode");
    chk_rts_when_full: assert property (rts |-> rx_valid)
        else $error("rts high with empty buffer");
    chk_tx_offline: assert property (!online |-> !tx_ready)
        else $error("tx accepted before online");
    chk_cts_holds: assert property (hw_flow_active && cts |-> !tx_ready)
        else $error("tx accepted while cts high");
    chk_tx_start: assert property (tx_valid && tx_ready |=> !txd)
        else $error("no start bit after accept");
    chk_rx_stands: assert property (rx_valid && !rx_ready |=>
        rx_valid && $stable(rx_data))
        else $error("received byte lost before taken");
    chk_cfg_steady: assert property ($past(rstn) && !cfg_wr |=>
        $stable(rate_sel) && $stable(hw_flow_active))
        else $error("configuration changed without setup");
    chk_drop_pulse: assert property (rx_dropped |=> !rx_dropped)
        else $error("drop flag longer than one cycle");
    chk_startup_wait: assert property (online |-> up_q >= STARTUP_WAIT)
        else $error("online too early");
    chk_xon_start: assert property ($rose(online) |-> ##[0:4] !txd)
        else $error("no announcement after online");
    cover property ($rose(rts));
    cover property (rx_dropped);
    cover property (hw_flow_active && tx_valid && tx_ready);
    cover property ($rose(online));
endmodule

bind overlay_serial_port overlay_serial_port_checker #(
    .STARTUP_WAIT(STARTUP_WAIT)
) overlay_serial_port_checker_inst (
    .ref_clk(ref_clk), .rstn(rstn), .cfg_wr(cfg_wr), .cts(cts),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .txd(txd), .rts(rts),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready),
    .online(online), .hw_flow_active(hw_flow_active),
    .rate_sel(rate_sel), .rx_dropped(rx_dropped)
);

/* overlay_serial_port_flow_control_bench.sv */
// Self-checking bench of the overlay serial port
module overlay_serial_port_flow_control_bench
    import overlay_serial_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rstn, cfg_wr, cfg_hw_flow, echo_en, rxd, txd, rts, cts;
    logic dbg_txd, spi_rx_valid, rx_valid, rx_ready, tx_valid, tx_ready;
    logic online, hw_flow_active, rx_dropped;
    logic [3:0] straps;
    logic [1:0] cfg_rate, rate_sel;
    logic [7:0] spi_rx_data, rx_data, tx_data;
    int bad_count = 0;
    int cmp_count = 0;
    int drop_seen = 0;
    overlay_serial_port #(.STARTUP_WAIT(200)) overlay_serial_port_inst (
        .ref_clk(ref_clk), .rstn(rstn), .rate_config_straps(straps),
        .cfg_wr(cfg_wr), .cfg_rate(cfg_rate), .cfg_hw_flow(cfg_hw_flow),
        .echo_en(echo_en), .rxd(rxd), .txd(txd), .rts(rts), .cts(cts),
        .dbg_txd(dbg_txd), .spi_rx_valid(spi_rx_valid),
        .spi_rx_data(spi_rx_data), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .online(online),
        .hw_flow_active(hw_flow_active), .rate_sel(rate_sel),
        .rx_dropped(rx_dropped)
    );
    overlay_serial_host main_host_inst (
        .ref_clk(ref_clk), .line_in(txd), .rts(rts), .line_out(rxd)
    );
    overlay_serial_host dbg_host_inst (
        .ref_clk(ref_clk), .line_in(dbg_txd), .rts(1'b0), .line_out()
    );
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (rx_dropped === 1'b1) drop_seen++;
    end
    ////////////////////////////////////////////////////////////////////////
    // Access tasks
    task automatic cmp(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic do_reset(input logic [3:0] s);
        @(negedge ref_clk);
        straps = s;
        rstn = 1'b0;
        repeat (3) @(negedge ref_clk);
        rstn = 1'b1;
        main_host_inst.got.delete();
        dbg_host_inst.got.delete();
        @(negedge ref_clk);
    endtask
    task automatic set_cfg(input logic [1:0] r, input logic h);
        cfg_rate = r;
        cfg_hw_flow = h;
        cfg_wr = 1'b1;
        @(negedge ref_clk);
        cfg_wr = 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic wait_q(input int n, input bit dbg);
        int k;
        k = 0;
        while ((dbg ? dbg_host_inst.got.size() : main_host_inst.got.size())
            < n && k < 40000) begin
            @(negedge ref_clk);
            k++;
        end
    endtask
    task automatic pop_rx(input logic [7:0] exp);
        int k;
        k = 0;
        while (rx_valid !== 1'b1 && k < 100) begin
            @(negedge ref_clk);
            k++;
        end
        cmp("rx_valid", 8'h01, 8'(rx_valid));
        cmp("rx_data", exp, rx_data);
        rx_ready = 1'b1;
        @(negedge ref_clk);
        rx_ready = 1'b0;
    endtask
    task automatic send_tx(input logic [7:0] b);
        int k;
        k = 0;
        tx_data = b;
        tx_valid = 1'b1;
        #1;
        while (tx_ready !== 1'b1 && k < 60000) begin
            @(negedge ref_clk);
            #1;
            k++;
        end
        @(negedge ref_clk);
        tx_valid = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Watchdog and tests
    initial begin
        repeat (95000) @(posedge ref_clk);
        bad_count++;
        $display("[ERR] run expected finish seen hang");
        final_report();
    end
    initial begin
        rstn = 1'b0;
        straps = 4'hb;
        cfg_wr = 1'b0;
        cfg_rate = 2'h0;
        cfg_hw_flow = 1'b0;
        echo_en = 1'b0;
        cts = 1'b0;
        spi_rx_valid = 1'b0;
        spi_rx_data = 8'h00;
        rx_ready = 1'b0;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        do_reset(4'hb);
        cmp("rate_sel", 8'h03, 8'(rate_sel));
        cmp("hw_flow", 8'h00, 8'(hw_flow_active));
        straps = 4'h4;
        repeat (5) @(negedge ref_clk);
        cmp("rate_sel", 8'h03, 8'(rate_sel));
        cmp("hw_flow", 8'h00, 8'(hw_flow_active));
        cmp("tx_ready", 8'h00, 8'(tx_ready));
        cmp("online", 8'h00, 8'(online));
        set_cfg(2'h2, 1'b0);
        cmp("rate_sel", 8'h02, 8'(rate_sel));
        set_cfg(2'h3, 1'b0);
        cmp("rate_sel", 8'h03, 8'(rate_sel));
        wait_q(1, 1'b0);
        cmp("txd", XON_CHAR, main_host_inst.got[0]);
        cmp("online", 8'h01, 8'(online));
        $display("test startup done");
        spi_rx_data = 8'hc3;
        spi_rx_valid = 1'b1;
        @(negedge ref_clk);
        spi_rx_valid = 1'b0;
        wait_q(1, 1'b1);
        cmp("dbg_txd", 8'hc3, dbg_host_inst.got[0]);
        main_host_inst.send_byte(8'h13, 1'b1);
        main_host_inst.send_byte(8'h11, 1'b1);
        send_tx(8'h5a);
        wait_q(3, 1'b0);
        cmp("txd", XOFF_CHAR, main_host_inst.got[1]);
        cmp("txd", 8'h5a, main_host_inst.got[2]);
        pop_rx(8'h13);
        pop_rx(8'h11);
        wait_q(4, 1'b0);
        cmp("txd", XON_CHAR, main_host_inst.got[3]);
        repeat (3000) @(negedge ref_clk);
        cmp("txd count", 8'h04, 8'(main_host_inst.got.size()));
        wait_q(3, 1'b1);
        cmp("dbg_txd", 8'h13, dbg_host_inst.got[1]);
        cmp("dbg_txd", 8'h11, dbg_host_inst.got[2]);
        $display("test software flow done");
        main_host_inst.div = 1302;
        do_reset(4'h6);
        cmp("rate_sel", 8'h02, 8'(rate_sel));
        cmp("hw_flow", 8'h01, 8'(hw_flow_active));
        set_cfg(2'h1, 1'b0);
        cmp("rate_sel", 8'h02, 8'(rate_sel));
        cmp("hw_flow", 8'h01, 8'(hw_flow_active));
        wait_q(1, 1'b0);
        cmp("txd", XON_CHAR, main_host_inst.got[0]);
        cts = 1'b1;
        tx_data = 8'ha5;
        tx_valid = 1'b1;
        repeat (50) @(negedge ref_clk);
        cmp("tx_ready", 8'h00, 8'(tx_ready));
        cts = 1'b0;
        send_tx(8'ha5);
        echo_en = 1'b1;
        main_host_inst.send_byte(8'h31, 1'b1);
        main_host_inst.send_byte(8'h32, 1'b1);
        main_host_inst.send_byte(8'h33, 1'b0);
        cmp("rts", 8'h01, 8'(rts));
        cmp("rx_dropped", 8'h01, 8'(drop_seen));
        pop_rx(8'h31);
        pop_rx(8'h32);
        repeat (3) @(negedge ref_clk);
        cmp("rx_valid", 8'h00, 8'(rx_valid));
        cmp("rts", 8'h00, 8'(rts));
        wait_q(4, 1'b0);
        cmp("txd", 8'ha5, main_host_inst.got[1]);
        cmp("txd", 8'h31, main_host_inst.got[2]);
        cmp("txd", 8'h32, main_host_inst.got[3]);
        $display("test hardware flow done");
        final_report();
    end
endmodule
